// [gcrw_pkg.sv]
// guest context root-write and guest timer: shared constants and types
// assumes one 100 MHz clock and an APB register port
package gcrw_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] OFS_ROOT_COUNT = 8'h00;
	localparam logic [7:0] OFS_TIME_OFFSET = 8'h04;
	localparam logic [7:0] OFS_GUEST_COUNT = 8'h08;
	localparam logic [7:0] OFS_GUEST_COMPARE = 8'h0C;
	localparam logic [7:0] OFS_GUEST_CAUSE = 8'h10;
	localparam logic [7:0] OFS_HV_CONTROL = 8'h14;
	localparam logic [7:0] OFS_GUEST_FEATURES = 8'h18;
	localparam logic [7:0] OFS_GUEST_XLAT = 8'h1C;
	localparam logic [7:0] OFS_FAULT_ADDR = 8'h20;
	localparam logic [7:0] OFS_FAULT_INSTR = 8'h24;
	localparam logic [7:0] OFS_PRIOR_INSTR = 8'h28;
	localparam logic [7:0] OFS_SHADOW_MISC = 8'h2C;
	localparam logic [7:0] OFS_FAULT_PAGE = 8'h30;
	localparam logic [7:0] OFS_WIRED = 8'h34;
	localparam logic [7:0] OFS_GUEST_STATUS = 8'h38;
	localparam logic [7:0] OFS_ROOT_COMPARE = 8'h3C;
	// hypervisor control word bit positions
	localparam int unsigned HV_ACCESS_BIT = 0;
	localparam int unsigned HV_ROOT_DC_BIT = 1;
	// guest status flag positions
	localparam int unsigned ST_SOFT_RESTART = 20;
	localparam int unsigned ST_NMI = 19;
	// xlat extension definition codes
	localparam logic [1:0] XDEF_BASIC = 2'h1;
	localparam logic [1:0] XDEF_ALT = 2'h3;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] RST_FEATURES = 32'h0000_0000;

	typedef struct packed {
		logic delay_slot_flag;
		logic guest_clock_irq_flag;
		logic [1:0] unusable_cop;
		logic count_disable_bit;
		logic [4:0] rsv_a;
		logic debug_channel_irq_flag;
		logic [4:0] rsv_b;
		logic [5:0] pending_irq_bits;
		logic [2:0] rsv_c;
		logic [4:0] exception_reason_code;
		logic [1:0] rsv_d;
	} gcrw_cause_t;

	typedef struct packed {
		logic probe_fail;
		logic rsv_a;
		logic [3:0] highest_shadow_set;
		logic [3:0] rsv_b;
		logic [3:0] ext_ctrl_shadow_set;
		logic [1:0] rsv_c;
		logic [9:0] core_number;
		logic [1:0] rsv_d;
		logic [3:0] current_shadow_set;
	} gcrw_shadow_t;
endpackage : gcrw_pkg

// [gcrw_top.sv]
// guest context registers writable from root, plus the guest timer
// assumes guest_mode, debug_mode and hw_register_read_instr come from the core on pclk
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Function
// R1 - root may optionally write guest feature-present flags
// R2 - shared translation buffer: root writes guest size and matching extension field
// R3 - hardware-set guest fields take root writes; guest writes do nothing
// R4 - reserved, static and random-index fields are not root writable
// R5 - root writes probe fail, fault page/address, shadow sets, cause fields, core number
// R6 - root writes timer and debug pending flags; pending bits optional
// R7 - root writes faulting and prior instructions; wired limit on release 6
// R8 - root writes reset flags optionally; never raise guest events
// R9 - guest count is root counter plus signed offset
// R10 - timer pending set when guest count equals compare, any mode
// R11 - access bit one: guest reads count, reads and writes compare
// R12 - guest write to count always raises privileged sensitive exception
// R13 - access bit zero: every guest count/compare access raises exception
// R14 - guest count-disable bit does not change guest time
// R15 - guest attempt to change count-disable raises field change exception
// R16 - root count-disable stops root counter in debug; guest follows
// R17 - guest timer interrupt only to guest; root timer never to guest
// R18 - root restores offset, cause, compare, then fixes pending itself
// R19 - root writes to guest count are ignored
// R20 - unsupported feature values written by root leave field unchanged
// R21 - guest never writes configuration fields
// R22 - offset and guest count are 32 bits, sum wraps
// R23 - compare write used by equality check from next cycle
module gcrw_top import gcrw_pkg::*; #(
	parameter logic [31:0] FEAT_WR_MASK = 32'h8000_00FF,
	parameter logic [31:0] FEAT_ROOT_HAS = 32'h8000_00FF,
	parameter bit SHARED_XLAT = 1'b1,
	parameter logic [1:0] XLAT_EXT_DEF = 2'h1,
	parameter bit SECOND_CTL = 1'b0,
	parameter bit RST_FLAGS_WR = 1'b1,
	parameter int unsigned RELEASE = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic guest_mode,
	input wire logic debug_mode,
	input wire logic hw_register_read_instr,
	output logic guest_timer_irq,
	output logic root_timer_irq,
	output logic guest_priv_exception,
	output logic guest_field_change_exception
);
	if (RELEASE < 1 || RELEASE > 6) begin : g_chk_rel
		$error("RELEASE out of range");
	end
	// a supported bit outside the writable mask could never be switched on
	if ((FEAT_ROOT_HAS & ~FEAT_WR_MASK) != 32'h0000_0000) begin : g_chk_feat
		$error("supported feature not writable");
	end

	logic [31:0] root_count_reg, root_count_next;
	logic [31:0] guest_time_offset_reg, guest_time_offset_next;
	logic [31:0] compare_reg, compare_next;
	logic [31:0] root_compare_reg, root_compare_next;
	gcrw_cause_t cause_reg, cause_next;
	logic [1:0] hv_reg, hv_next;
	logic [31:0] feat_reg, feat_next;
	logic [5:0] xsize_reg, xsize_next;
	logic [7:0] xext_reg, xext_next;
	logic [7:0] xalt_reg, xalt_next;
	logic [31:0] faddr_reg, faddr_next;
	logic [31:0] finstr_reg, finstr_next;
	logic [31:0] pinstr_reg, pinstr_next;
	gcrw_shadow_t shadow_reg, shadow_next;
	logic [18:0] fpage_reg, fpage_next;
	logic [15:0] wired_reg, wired_next;
	logic sr_reg, sr_next;
	logic nmi_reg, nmi_next;
	logic [31:0] prdata_reg, prdata_next;
	logic err_reg, err_next;
	logic gpe_reg, gpe_next;
	logic gfc_reg, gfc_next;
	logic [31:0] guest_count;
	logic acc, root_wr, guest_wr, access_ok;

	assign guest_count = root_count_reg + guest_time_offset_reg; // R9 R14 R22
	assign acc = psel && penable;
	assign root_wr = acc && pwrite && !guest_mode;
	assign guest_wr = acc && pwrite && guest_mode;
	assign access_ok = hv_reg[HV_ACCESS_BIT];

	always_comb begin
		root_count_next = root_count_reg;
		guest_time_offset_next = guest_time_offset_reg;
		compare_next = compare_reg;
		root_compare_next = root_compare_reg;
		cause_next = cause_reg;
		hv_next = hv_reg;
		feat_next = feat_reg;
		xsize_next = xsize_reg;
		xext_next = xext_reg;
		xalt_next = xalt_reg;
		faddr_next = faddr_reg;
		finstr_next = finstr_reg;
		pinstr_next = pinstr_reg;
		shadow_next = shadow_reg;
		fpage_next = fpage_reg;
		wired_next = wired_reg;
		sr_next = sr_reg;
		nmi_next = nmi_reg;
		prdata_next = prdata_reg;
		err_next = err_reg;
		gpe_next = 1'b0;
		gfc_next = 1'b0;
		// root counter freezes only in debug with root count-disable set
		if (!(debug_mode && hv_reg[HV_ROOT_DC_BIT])) begin // R16
			root_count_next = root_count_reg + 32'h0000_0001;
		end
		// read data and error captured in the setup cycle, shown in access
		if (psel && !penable) begin
			prdata_next = 32'h0000_0000;
			err_next = 1'b0;
			unique case (paddr)
				OFS_ROOT_COUNT: begin
					prdata_next = root_count_reg;
					err_next = guest_mode;
				end
				OFS_TIME_OFFSET: begin
					prdata_next = guest_time_offset_reg;
					err_next = guest_mode;
				end
				OFS_GUEST_COUNT: begin
					prdata_next = (guest_mode && !access_ok) ? 32'h0000_0000 : guest_count; // R11 R13
					err_next = guest_mode && (pwrite || !access_ok);
				end
				OFS_GUEST_COMPARE: begin
					prdata_next = (guest_mode && !access_ok) ? 32'h0000_0000 : compare_reg;
					err_next = guest_mode && !access_ok;
				end
				OFS_GUEST_CAUSE: prdata_next = cause_reg;
				OFS_HV_CONTROL: begin
					prdata_next = {30'h0000_0000, hv_reg};
					err_next = guest_mode;
				end
				OFS_GUEST_FEATURES: prdata_next = feat_reg;
				OFS_GUEST_XLAT: prdata_next = {1'b0, xsize_reg, 1'b0, xext_reg, xalt_reg, 6'h00, XLAT_EXT_DEF};
				OFS_FAULT_ADDR: prdata_next = faddr_reg;
				OFS_FAULT_INSTR: prdata_next = finstr_reg;
				OFS_PRIOR_INSTR: prdata_next = pinstr_reg;
				OFS_SHADOW_MISC: prdata_next = shadow_reg;
				OFS_FAULT_PAGE: prdata_next = {9'h000, fpage_reg, 4'h0};
				OFS_WIRED: prdata_next = {wired_reg, 16'h0000};
				OFS_GUEST_STATUS: prdata_next = {11'h000, sr_reg, nmi_reg, 19'h00000};
				OFS_ROOT_COMPARE: begin
					prdata_next = root_compare_reg;
					err_next = guest_mode;
				end
				default: err_next = 1'b1;
			endcase
		end
		// guest count/compare permission checks
		if (acc && guest_mode) begin
			if (paddr == OFS_GUEST_COUNT && (pwrite || !access_ok)) begin // R12 R13
				gpe_next = 1'b1;
			end
			if (paddr == OFS_GUEST_COMPARE && !access_ok) begin // R13
				gpe_next = 1'b1;
			end
		end
		if (guest_mode && hw_register_read_instr && !access_ok) begin // R13
			gpe_next = 1'b1;
		end
		if (guest_wr && paddr == OFS_GUEST_COMPARE && access_ok) begin // R11
			compare_next = pwdata;
		end
		// guest writes to cause change nothing; a count-disable change traps
		if (guest_wr && paddr == OFS_GUEST_CAUSE) begin
			gfc_next = pwdata[27] != cause_reg.count_disable_bit; // R15 R3
		end
		if (root_wr) begin // R21
			unique case (paddr)
				OFS_ROOT_COUNT: root_count_next = pwdata;
				OFS_TIME_OFFSET: guest_time_offset_next = pwdata;
				OFS_GUEST_COUNT: ; // R19
				OFS_GUEST_COMPARE: compare_next = pwdata; // R23
				OFS_GUEST_CAUSE: begin
					cause_next.delay_slot_flag = pwdata[31]; // R5
					cause_next.guest_clock_irq_flag = pwdata[30]; // R6
					cause_next.unusable_cop = pwdata[29:28]; // R5
					cause_next.count_disable_bit = pwdata[27];
					cause_next.debug_channel_irq_flag = pwdata[21]; // R6
					if (!SECOND_CTL) begin // R6
						cause_next.pending_irq_bits = pwdata[15:10];
					end
					cause_next.exception_reason_code = pwdata[6:2]; // R5
				end
				OFS_HV_CONTROL: hv_next = pwdata[1:0];
				OFS_GUEST_FEATURES: begin
					// a bit is taken only if writable and its value supported
					for (int i = 0; i < 32; i++) begin
						if (FEAT_WR_MASK[i] && (!pwdata[i] || FEAT_ROOT_HAS[i])) begin // R1 R20
							feat_next[i] = pwdata[i];
						end
					end
				end
				OFS_GUEST_XLAT: begin
					if (SHARED_XLAT) begin // R2
						xsize_next = pwdata[30:25];
						if (XLAT_EXT_DEF == XDEF_BASIC) begin
							xext_next = pwdata[23:16];
						end
						if (XLAT_EXT_DEF == XDEF_ALT) begin
							xalt_next = pwdata[15:8];
						end
					end
				end
				OFS_FAULT_ADDR: faddr_next = pwdata; // R5
				OFS_FAULT_INSTR: finstr_next = pwdata; // R7
				OFS_PRIOR_INSTR: pinstr_next = pwdata; // R7
				OFS_SHADOW_MISC: begin
					// reserved bits stay zero
					shadow_next = pwdata & 32'hBC3C_FFCF; // R4 R5
				end
				OFS_FAULT_PAGE: fpage_next = pwdata[22:4]; // R5
				OFS_WIRED: begin
					if (RELEASE >= 6) begin // R7
						wired_next = pwdata[31:16];
					end
				end
				OFS_GUEST_STATUS: begin
					// flags are stored only; no guest event is raised
					if (RST_FLAGS_WR) begin // R8
						sr_next = pwdata[ST_SOFT_RESTART];
						nmi_next = pwdata[ST_NMI];
					end
				end
				OFS_ROOT_COMPARE: root_compare_next = pwdata;
				default: ;
			endcase
		end
		// set beats a same-cycle root clear of the pending flag
		if (guest_count == compare_reg) begin // R10
			cause_next.guest_clock_irq_flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			root_count_reg <= RST_WORD;
			guest_time_offset_reg <= RST_WORD;
			compare_reg <= RST_WORD;
			root_compare_reg <= RST_WORD;
			cause_reg <= RST_WORD;
			hv_reg <= 2'h0;
			feat_reg <= RST_FEATURES;
			xsize_reg <= 6'h00;
			xext_reg <= 8'h00;
			xalt_reg <= 8'h00;
			faddr_reg <= RST_WORD;
			finstr_reg <= RST_WORD;
			pinstr_reg <= RST_WORD;
			shadow_reg <= RST_WORD;
			fpage_reg <= 19'h00000;
			wired_reg <= 16'h0000;
			sr_reg <= 1'b0;
			nmi_reg <= 1'b0;
			prdata_reg <= RST_WORD;
			err_reg <= 1'b0;
			gpe_reg <= 1'b0;
			gfc_reg <= 1'b0;
		end else begin
			root_count_reg <= root_count_next;
			guest_time_offset_reg <= guest_time_offset_next;
			compare_reg <= compare_next;
			root_compare_reg <= root_compare_next;
			cause_reg <= cause_next;
			hv_reg <= hv_next;
			feat_reg <= feat_next;
			xsize_reg <= xsize_next;
			xext_reg <= xext_next;
			xalt_reg <= xalt_next;
			faddr_reg <= faddr_next;
			finstr_reg <= finstr_next;
			pinstr_reg <= pinstr_next;
			shadow_reg <= shadow_next;
			fpage_reg <= fpage_next;
			wired_reg <= wired_next;
			sr_reg <= sr_next;
			nmi_reg <= nmi_next;
			prdata_reg <= prdata_next;
			err_reg <= err_next;
			gpe_reg <= gpe_next;
			gfc_reg <= gfc_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = acc && err_reg;
	assign guest_priv_exception = gpe_reg;
	assign guest_field_change_exception = gfc_reg;
	// the guest line is fed by the guest flag alone, the root line by root state alone
	assign guest_timer_irq = cause_reg.guest_clock_irq_flag; // R17
	assign root_timer_irq = root_count_reg == root_compare_reg; // R17

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_cmp_write;
		root_wr && paddr == OFS_GUEST_COMPARE;
	endsequence
	property p_ti_set;
		guest_count == compare_reg |=> guest_timer_irq;
	endproperty
	a_ti_set: assert property (p_ti_set) else $error("pending flag not set on match"); // R10
	property p_cmp_next;
		logic [31:0] v;
		(s_cmp_write, v = pwdata) |=> compare_reg == v;
	endproperty
	a_cmp_next: assert property (p_cmp_next) else $error("compare not updated"); // R23
	property p_offset;
		logic [31:0] v;
		(root_wr && paddr == OFS_TIME_OFFSET, v = pwdata)
			|=> guest_count == root_count_reg + v;
	endproperty
	a_offset: assert property (p_offset) else $error("guest count not root plus offset"); // R9
	property p_count_ignored;
		root_wr && paddr == OFS_GUEST_COUNT |=> $stable(guest_time_offset_reg);
	endproperty
	a_count_ignored: assert property (p_count_ignored) else $error("root count write changed offset"); // R19
	property p_guest_wr_count;
		guest_wr && paddr == OFS_GUEST_COUNT |=> guest_priv_exception ##1 !guest_priv_exception;
	endproperty
	a_guest_wr_count: assert property (p_guest_wr_count) else $error("no exception on count write"); // R12
	property p_no_access;
		acc && guest_mode && !access_ok && (paddr == OFS_GUEST_COMPARE) |=> guest_priv_exception;
	endproperty
	a_no_access: assert property (p_no_access) else $error("no exception without access"); // R13
	property p_dc_change;
		guest_wr && paddr == OFS_GUEST_CAUSE && pwdata[27] != cause_reg.count_disable_bit
			|=> guest_field_change_exception && $stable(cause_reg.count_disable_bit);
	endproperty
	a_dc_change: assert property (p_dc_change) else $error("count-disable change not trapped"); // R15
	property p_guest_noeffect;
		guest_wr && paddr == OFS_FAULT_ADDR |=> $stable(faddr_reg);
	endproperty
	a_guest_noeffect: assert property (p_guest_noeffect) else $error("guest changed fault address"); // R3
	property p_debug_hold;
		debug_mode && hv_reg[HV_ROOT_DC_BIT] && !root_wr |=> $stable(root_count_reg);
	endproperty
	a_debug_hold: assert property (p_debug_hold) else $error("root counter ran while disabled"); // R16
endmodule : gcrw_top

`default_nettype wire

// [guest_context_root_write_and_timer_tb.sv]
// self-checking bench for the guest context root-write and guest timer block
// assumes a zero-wait apb slave; the bench drives every design input itself
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module guest_context_root_write_and_timer_tb import gcrw_pkg::*;;
	typedef struct packed {logic [31:0] m; logic [31:0] d; logic e;} gcrw_exp_t;
	gcrw_exp_t q[$];
	gcrw_exp_t e;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic guest_mode = 0, debug_mode = 0, hw_register_read_instr = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, r, x, y;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, guest_timer_irq, root_timer_irq, guest_priv_exception, guest_field_change_exception;
	int errors = 0, check_count = 0, cyc = 0, gpe_n = 0, gfc_n = 0, g0, f0;
	int seed = 32'hd54359a6;
	logic [7:0] ra [8] = '{OFS_FAULT_ADDR, OFS_FAULT_INSTR, OFS_PRIOR_INSTR, OFS_SHADOW_MISC, OFS_FAULT_PAGE,
		OFS_WIRED, OFS_GUEST_STATUS, OFS_GUEST_CAUSE};
	logic [31:0] rm [8] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hBC3C_FFCF, 32'h007F_FFF0,
		32'hFFFF_0000, 32'h0018_0000, 32'hF820_FC7C};

	// bits 7:4 left unsupported so root writes of one there must be dropped
	gcrw_top #(.FEAT_ROOT_HAS(32'h8000_000F)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .guest_mode(guest_mode), .debug_mode(debug_mode),
		.hw_register_read_instr(hw_register_read_instr), .guest_timer_irq(guest_timer_irq),
		.root_timer_irq(root_timer_irq), .guest_priv_exception(guest_priv_exception),
		.guest_field_change_exception(guest_field_change_exception));

	always #5 pclk = ~pclk;

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// each transfer starts with one idle edge ahead of its setup so no strobe is driven twice in a step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] ed, input logic ee);
		q.push_back('{m, ed & m, ee});
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		xfer(1, a, d, 0, 0, ee);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed, input logic ee);
		xfer(0, a, 0, m, ed, ee);
	endtask : rd

	task automatic gm(input logic g);
		@(posedge pclk);
		guest_mode <= g;
	endtask : gm

	task automatic note(input string s);
		repeat (3) @(posedge pclk);
		$display("test %s done", s);
	endtask : note

	// monitor: oldest queued expectation is matched against each completed transfer
	always @(posedge pclk) begin
		cyc++;
		gpe_n += guest_priv_exception;
		gfc_n += guest_field_change_exception;
		if (cyc > 4000) begin
			errors++;
			wrap_up();
		end
		if (psel && penable && pready) begin
			e = q.pop_front();
			`CHK("pslverr", e.e, pslverr)
			`CHK("prdata", e.d, prdata & e.m)
		end
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rd(OFS_GUEST_CAUSE, '1, 32'h4000_0000, 0);
		rd(OFS_HV_CONTROL, '1, 0, 0);
		note("reset");
		debug_mode <= 1;
		wr(OFS_HV_CONTROL, 32'h3, 0);
		x = $random(seed);
		r = $random(seed) | 32'h8000_0000;
		wr(OFS_ROOT_COUNT, x, 0);
		wr(OFS_TIME_OFFSET, r, 0);
		rd(OFS_ROOT_COUNT, '1, x, 0);
		rd(OFS_GUEST_COUNT, '1, x + r, 0);
		wr(OFS_GUEST_COUNT, ~x, 0);
		rd(OFS_GUEST_COUNT, '1, x + r, 0);
		wr(OFS_GUEST_CAUSE, 32'h0800_0000, 0);
		rd(OFS_GUEST_COUNT, '1, x + r, 0);
		wr(OFS_GUEST_COMPARE, x + r + 1, 0);
		rd(OFS_GUEST_CAUSE, '1, 32'h0800_0000, 0);
		wr(OFS_GUEST_COMPARE, x + r, 0);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("guest_irq", 1'b1, guest_timer_irq)
		rd(OFS_GUEST_CAUSE, '1, 32'h4800_0000, 0);
		wr(OFS_GUEST_COMPARE, x + r + 5, 0);
		wr(OFS_GUEST_CAUSE, 0, 0);
		wr(OFS_ROOT_COMPARE, x, 0);
		#1;
		`CHK("root_irq", 1'b1, root_timer_irq)
		`CHK("guest_irq", 1'b0, guest_timer_irq)
		note("timer");
		y = $random(seed);
		g0 = gpe_n;
		gm(1);
		rd(OFS_GUEST_COUNT, '1, x + r, 0);
		wr(OFS_GUEST_COMPARE, y, 0);
		rd(OFS_GUEST_COMPARE, '1, y, 0);
		wr(OFS_GUEST_COUNT, y, 1);
		note("guest open");
		`CHK("gpe_count", g0 + 1, gpe_n)
		gm(0);
		wr(OFS_HV_CONTROL, 32'h2, 0);
		gm(1);
		rd(OFS_GUEST_COUNT, '1, 0, 1);
		rd(OFS_GUEST_COMPARE, '1, 0, 1);
		hw_register_read_instr <= 1;
		@(posedge pclk);
		hw_register_read_instr <= 0;
		f0 = gfc_n;
		wr(OFS_GUEST_CAUSE, 32'h0800_0000, 0);
		wr(OFS_FAULT_ADDR, 32'hFFFF_FFFF, 0);
		wr(OFS_GUEST_FEATURES, 32'hFFFF_FFFF, 0);
		note("guest closed");
		`CHK("gpe_count", g0 + 4, gpe_n)
		`CHK("gfc_count", f0 + 1, gfc_n)
		gm(0);
		rd(OFS_GUEST_CAUSE, 32'h0800_0000, 0, 0);
		rd(OFS_FAULT_ADDR, '1, 0, 0);
		rd(OFS_GUEST_FEATURES, '1, 0, 0);
		g0 = gpe_n;
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			wr(ra[i], r, 0);
			rd(ra[i], '1, r & rm[i], 0);
		end
		note("root fields");
		`CHK("gpe_count", g0, gpe_n)
		debug_mode <= 0;
		wr(OFS_ROOT_COUNT, x, 0);
		rd(OFS_ROOT_COUNT, '1, x + 32'h0000_0001, 0);
		wr(OFS_GUEST_FEATURES, 32'hFFFF_FFFF, 0);
		rd(OFS_GUEST_FEATURES, '1, 32'h8000_000F, 0);
		wr(OFS_GUEST_XLAT, 32'hFFFF_FFFF, 0);
		rd(OFS_GUEST_XLAT, 32'h7EFF_FF03, 32'h7EFF_0001, 0);
		wr(8'h40, r, 1);
		rd(8'h40, '1, 0, 1);
		note("config");
		wrap_up();
	end
endmodule : guest_context_root_write_and_timer_tb
`default_nettype wire
